// ===== adcx_i2c_conv.sv
`timescale 1ns/1ps
`include "adcx_params.svh"

module adcx_i2c_conv #(
    parameter int CONV_CYCLES = `ADCX_CONV_CYCLES
) (
    // System clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Link sampling clock and bus pins
    input wire logic i2c_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Pin-selected device address
    input wire logic [6:0] dev_addr,
    // Converter core
    input wire logic signed [31:0] meas_raw,
    output adcx_pkg::adcx_cfg_t mode_cfg,
    output logic chop_phase,
    output logic sleep_mode
);
    import adcx_pkg::*;

    // Link-domain synchronisers and edge history
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic [6:0] addr_s1, addr_s2;
    logic rdy_s1, rdy_s2, rdy_s3;
    logic scl_rise, scl_fall, start_c, stop_c, rdy_rise;

    // Link-domain transfer state
    adcx_link_st_t lst;
    logic [3:0] bcnt;
    logic [7:0] shreg;
    logic rw;
    logic addr_ok;
    logic sel;
    logic [4:0] ridx;
    logic mack;
    logic got_byte;
    logic pend_ok;
    logic [7:0] cfg_pend;
    logic [7:0] cfg_out;
    logic start_req;
    logic start_tgl;
    logic avail;
    logic addr_hit;

    // Converter-domain state
    logic st_s1, st_s2, st_s3;
    logic start_ev;
    adcx_conv_st_t cst;
    logic [31:0] cnt;
    logic cnt_end;
    logic signed [31:0] s1;
    logic signed [32:0] diff;
    logic signed [31:0] res_val;
    logic res_done;
    logic fast;
    logic ready;
    logic zsign;
    logic [31:0] res_word;
    adcx_cfg_t cfg_in;

    // Pack a filter value into the output word
    function automatic logic [31:0] adcx_fmt(input logic signed [31:0] v,
                                             input logic dbl,
                                             input logic zs);
        logic [31:0] w;
        w = {~v[31], v[30:0]};
        if (v >= `ADCX_FS_POS) begin
            w = `ADCX_OVER_WORD;
        end else if (v < `ADCX_FS_NEG) begin
            w = dbl ? `ADCX_UNDER2X_WORD : `ADCX_UNDER_WORD;
        end else if (v == 32'sh00000000) begin
            w = {(dbl ? zs : 1'b1), 31'h00000000};
        end
        return w;
    endfunction : adcx_fmt

    // Open-drain data line only ever pulls low
    assign sda_o = 1'b0;
    assign sleep_mode = ready;

    // Two-stage sync of pins and ready level into link domain
    always_ff @(posedge i2c_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            addr_s1 <= 7'h00;
            addr_s2 <= 7'h00;
            rdy_s1 <= 1'b0;
            rdy_s2 <= 1'b0;
            rdy_s3 <= 1'b0;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            addr_s1 <= dev_addr;
            addr_s2 <= addr_s1;
            rdy_s1 <= ready;
            rdy_s2 <= rdy_s1;
            rdy_s3 <= rdy_s2;
        end
    end

    // Bus events from synchronised lines
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign start_c = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
    assign stop_c = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;
    assign rdy_rise = rdy_s2 & ~rdy_s3;
    // Own address match, or global address with write direction only
    assign addr_hit = (shreg[7:1] == addr_s2) ||
                      (shreg[7:1] == `ADCX_GLOBAL_ADDR && !shreg[0]);

    // Slave transfer sequencer
    always_ff @(posedge i2c_clk or negedge rst_n) begin
        if (!rst_n) begin
            lst <= LK_IDLE;
            bcnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            addr_ok <= 1'b0;
            sel <= 1'b0;
            ridx <= 5'h00;
            mack <= 1'b0;
            got_byte <= 1'b0;
            pend_ok <= 1'b0;
            cfg_pend <= `ADCX_CFG_RESET;
            sda_oe_n <= 1'b1;
            start_req <= 1'b0;
        end else begin
            start_req <= 1'b0;
            if (start_req) begin
                pend_ok <= 1'b0;
            end
            if (start_c) begin
                lst <= LK_ADDR;
                bcnt <= 4'h0;
                sda_oe_n <= 1'b1;
                got_byte <= 1'b0;
            end else if (stop_c) begin
                lst <= LK_IDLE;
                sda_oe_n <= 1'b1;
                sel <= 1'b0;
                if (sel) begin
                    start_req <= 1'b1;
                end
            end else if (scl_rise) begin
                case (lst)
                    LK_ADDR, LK_WDAT: begin
                        shreg <= {shreg[6:0], sda_s2};
                        bcnt <= bcnt + 4'h1;
                    end
                    LK_RACK: begin
                        mack <= ~sda_s2;
                    end
                    default: begin
                    end
                endcase
            end else if (scl_fall) begin
                case (lst)
                    LK_ADDR: begin
                        if (bcnt == `ADCX_BYTE_BITS) begin
                            rw <= shreg[0];
                            addr_ok <= addr_hit;
                            if (addr_hit && avail) begin
                                lst <= LK_AACK;
                                sda_oe_n <= 1'b0;
                            end else begin
                                lst <= LK_SKIP;
                            end
                        end
                    end
                    LK_AACK: begin
                        sel <= 1'b1;
                        if (rw) begin
                            lst <= LK_RDAT;
                            ridx <= `ADCX_FIRST_BIT;
                            sda_oe_n <= res_word[31];
                        end else begin
                            lst <= LK_WDAT;
                            bcnt <= 4'h0;
                            sda_oe_n <= 1'b1;
                        end
                    end
                    LK_WDAT: begin
                        if (bcnt == `ADCX_BYTE_BITS) begin
                            if (!got_byte) begin
                                cfg_pend <= shreg;
                                pend_ok <= 1'b1;
                                got_byte <= 1'b1;
                                lst <= LK_WACK;
                                sda_oe_n <= 1'b0;
                            end else begin
                                lst <= LK_SKIP;
                            end
                        end
                    end
                    LK_WACK: begin
                        lst <= LK_WDAT;
                        bcnt <= 4'h0;
                        sda_oe_n <= 1'b1;
                    end
                    LK_RDAT: begin
                        if (ridx[2:0] == 3'h0) begin
                            lst <= LK_RACK;
                            sda_oe_n <= 1'b1;
                        end else begin
                            ridx <= ridx - 5'h01;
                            sda_oe_n <= res_word[ridx - 5'h01];
                        end
                    end
                    LK_RACK: begin
                        if (ridx == `ADCX_LAST_BIT) begin
                            start_req <= 1'b1;
                            sel <= 1'b0;
                            lst <= LK_SKIP;
                        end else if (mack) begin
                            ridx <= ridx - 5'h01;
                            sda_oe_n <= res_word[ridx - 5'h01];
                            lst <= LK_RDAT;
                        end else begin
                            lst <= LK_SKIP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Result availability and start request toward the converter
    always_ff @(posedge i2c_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_tgl <= 1'b0;
            avail <= 1'b0;
            cfg_out <= `ADCX_CFG_RESET;
        end else if (start_req) begin
            start_tgl <= ~start_tgl;
            avail <= 1'b0;
            if (pend_ok) begin
                cfg_out <= cfg_pend;
            end
        end else if (rdy_rise) begin
            avail <= 1'b1;
        end
    end

    // Start toggle sync into converter domain
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_s1 <= 1'b0;
            st_s2 <= 1'b0;
            st_s3 <= 1'b0;
        end else begin
            st_s1 <= start_tgl;
            st_s2 <= st_s1;
            st_s3 <= st_s2;
        end
    end

    assign start_ev = st_s2 ^ st_s3;
    assign cfg_in = cfg_out;

    // Active mode, taken only when a conversion is started
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_cfg <= `ADCX_CFG_RESET;
        end else if (start_ev) begin
            mode_cfg <= cfg_in;
            mode_cfg.double_rate_select <= cfg_in.double_rate_select &
                                           ~cfg_in.input_select_temp;
        end
    end

    // Conversion timing and offset-cancel combining
    assign fast = mode_cfg.double_rate_select;
    assign cnt_end = (cnt == 32'(CONV_CYCLES - 1));
    assign diff = {s1[31], s1} - {meas_raw[31], meas_raw};
    assign res_val = (cst == CV_CONV2) ? diff[32:1] : meas_raw;
    assign res_done = cnt_end && ((cst == CV_CONV1 && fast) || cst == CV_CONV2);

    // Conversion sequencer, running from reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cst <= CV_CONV1;
            cnt <= 32'h00000000;
            s1 <= 32'sh00000000;
            chop_phase <= 1'b0;
        end else if (start_ev) begin
            cst <= CV_CONV1;
            cnt <= 32'h00000000;
            chop_phase <= 1'b0;
        end else begin
            case (cst)
                CV_CONV1: begin
                    if (cnt_end) begin
                        cnt <= 32'h00000000;
                        s1 <= meas_raw;
                        if (fast) begin
                            cst <= CV_SLEEP;
                        end else begin
                            cst <= CV_CONV2;
                            chop_phase <= 1'b1;
                        end
                    end else begin
                        cnt <= cnt + 32'h00000001;
                    end
                end
                CV_CONV2: begin
                    if (cnt_end) begin
                        cnt <= 32'h00000000;
                        cst <= CV_SLEEP;
                        chop_phase <= 1'b0;
                    end else begin
                        cnt <= cnt + 32'h00000001;
                    end
                end
                CV_SLEEP: begin
                    cnt <= 32'h00000000;
                end
                default: begin
                    cst <= CV_CONV1;
                end
            endcase
        end
    end

    // Held result word and ready level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ready <= 1'b0;
            res_word <= 32'h00000000;
            zsign <= 1'b0;
        end else if (start_ev) begin
            ready <= 1'b0;
        end else if (res_done) begin
            ready <= 1'b1;
            res_word <= adcx_fmt(res_val, fast, zsign);
            if (fast && res_val == 32'sh00000000) begin
                zsign <= ~zsign;
            end
        end
    end

    // Checks on the link side
    sequence s_addr_end;
        lst == LK_ADDR && scl_fall && bcnt == `ADCX_BYTE_BITS && !start_c && !stop_c;
    endsequence

    sequence s_rd_end;
        lst == LK_RACK && scl_fall && ridx == 5'h00 && !start_c && !stop_c;
    endsequence

    property p_ack_ok;
        @(posedge i2c_clk) disable iff (!rst_n)
        lst == LK_AACK |-> (!sda_oe_n && addr_ok && avail);
    endproperty
    a_ack_ok: assert property (p_ack_ok) else $error("ack without ready match");

    property p_nak_busy;
        @(posedge i2c_clk) disable iff (!rst_n)
        (s_addr_end and (##0 !avail)) |=> (lst == LK_SKIP && sda_oe_n);
    endproperty
    a_nak_busy: assert property (p_nak_busy) else $error("busy address acked");

    property p_rd_end;
        @(posedge i2c_clk) disable iff (!rst_n)
        s_rd_end |-> ##2 (!avail && start_tgl != $past(start_tgl));
    endproperty
    a_rd_end: assert property (p_rd_end) else $error("no restart after read");

    property p_stop_start;
        @(posedge i2c_clk) disable iff (!rst_n)
        (stop_c && sel) |-> ##2 (start_tgl != $past(start_tgl));
    endproperty
    a_stop_start: assert property (p_stop_start) else $error("stop did not restart");

    // Checks on the converter side
    sequence s_first_done;
        cst == CV_CONV1 && cnt_end && !fast && !start_ev;
    endsequence

    property p_two_conv;
        @(posedge mclk) disable iff (!rst_n)
        s_first_done |=> (cst == CV_CONV2 && chop_phase && !ready);
    endproperty
    a_two_conv: assert property (p_two_conv) else $error("1x skipped second phase");

    property p_fast;
        @(posedge mclk) disable iff (!rst_n)
        (cst == CV_CONV1 && cnt_end && fast && !start_ev) |=> (ready && cst == CV_SLEEP);
    endproperty
    a_fast: assert property (p_fast) else $error("2x result not ready");

    property p_temp_1x;
        @(posedge mclk) disable iff (!rst_n)
        mode_cfg.input_select_temp |-> !mode_cfg.double_rate_select;
    endproperty
    a_temp_1x: assert property (p_temp_1x) else $error("temp input at 2x");

    property p_cfg_hold;
        @(posedge mclk) disable iff (!rst_n)
        $changed(mode_cfg) |-> $past(start_ev);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("mode changed unstarted");

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        (ready && !start_ev) |=> (ready && $stable(res_word));
    endproperty
    a_hold: assert property (p_hold) else $error("held result lost");

    property p_over;
        @(posedge mclk) disable iff (!rst_n)
        (ready && res_word[31:30] == 2'b11) |-> res_word[29:6] == 24'h000000;
    endproperty
    a_over: assert property (p_over) else $error("bad overrange word");

    property p_under;
        @(posedge mclk) disable iff (!rst_n)
        (ready && res_word[31:30] == 2'b00) |->
            (fast ? (res_word[29:16] == 14'h3FFF || res_word[29:0] == 30'h00000000)
                  : res_word[29:6] == `ADCX_RANGE_LO_ONES);
    endproperty
    a_under: assert property (p_under) else $error("bad underrange word");

endmodule : adcx_i2c_conv

// ===== adcx_i2c_conv_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t: got %h exp %h", $time, (a), (e)); end end

module adcx_i2c_conv_tb;
    import adcx_pkg::*;
    localparam int CONV = 700;
    localparam logic [6:0] ADDR = 7'h14;
    logic mclk, i2c_clk, rst_n, scl, sda_m, sda, sda_o, sda_oe_n;
    logic chop_phase, sleep_mode, chop_seen, dbl;
    logic [6:0] dev_addr;
    logic signed [31:0] v, meas_raw;
    logic signed [31:0] vals [7] = '{0, 32'sh3FFFFFC0, -32'sh40000040, 0,
        32'sh50000000, -64, -32'sh40000040};
    // Reserved bits low, never both rejection bits
    logic [7:0] cfgs [7] = '{8'h02, 8'h04, 8'h01, 8'h05, 8'h08, 8'h0A, 8'h0D};
    adcx_cfg_t mode_cfg;
    logic [63:0] expq [$];
    logic [63:0] e;
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed = 32'h814E5844;

    // System clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Link clock, unrelated phase
    initial begin
        i2c_clk = 1'b0;
        #17.3;
        forever #62.5 i2c_clk = ~i2c_clk;
    end

    // Open-drain data wire with pull-up; core input reversed when chopped
    assign sda = (sda_m && (sda_oe_n || sda_o)) ? 1'b1 : 1'b0;
    assign meas_raw = chop_phase ? -v : v;

    adcx_i2c_conv #(.CONV_CYCLES(CONV)) i_adcx_i2c_conv (
        .mclk(mclk), .rst_n(rst_n), .i2c_clk(i2c_clk), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .dev_addr(dev_addr),
        .meas_raw(meas_raw), .mode_cfg(mode_cfg), .chop_phase(chop_phase),
        .sleep_mode(sleep_mode)
    );

    adcx_i2c_master i_adcx_i2c_master (.mclk(mclk), .scl(scl), .sda_m(sda_m), .sda(sda));

    // Cycle limit and chopped-phase monitor
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (chop_phase === 1'b1) chop_seen <= 1'b1;
        if (cyc == 110000) begin
            n_mismatch++;
            $display("Error %0t: cycle limit reached", $time);
            give_verdict();
        end
    end

    // Result watcher against the oldest note
    always @(i_adcx_i2c_master.got) begin
        if (expq.size() == 0) begin
            n_mismatch++;
            $display("Error %0t: unexpected result", $time);
        end else begin
            e = expq.pop_front();
            `CHK(i_adcx_i2c_master.got_val & e[63:32], e[31:0])
        end
    end

    // Expected word with its care mask in the upper half
    function automatic logic [63:0] word(input logic signed [31:0] x, input logic d);
        if (x >= 32'sh40000000) return {32'hFFFFFFFF, 32'hC0000000};
        if (x < -32'sh40000000) return d ? {32'hFFFF0000, 32'h3FFF0000} :
            {32'hFFFFFFFF, 32'h3FFFFFFF};
        if (d && x == 0) return {32'h7FFFFFFF, 32'h0};
        return {32'hFFFFFFFF, ~x[31], x[30:0]};
    endfunction : word

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    task automatic wait_lvl(input logic lvl, input int lim);
        int n = 0;
        while (sleep_mode !== lvl && n < lim) begin
            @(posedge mclk);
            n++;
        end
        `CHK(sleep_mode, lvl)
    endtask : wait_lvl

    task automatic rd(input logic [6:0] a, input logic ack, input int nb,
                      input logic [63:0] w);
        logic [31:0] m;
        m = w[63:32] & ~(32'hFFFFFFFF >> (8 * nb));
        expq.push_back({32'h1, 31'h0, ack});
        if (ack) expq.push_back({m, w[31:0] & m});
        i_adcx_i2c_master.rd(a, nb);
    endtask : rd

    // Acked write, then wait out the restarted conversion
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb);
        expq.push_back({32'h1, 32'h1});
        i_adcx_i2c_master.wr(a, d, nb);
        wait_lvl(1'b0, 300);
        wait_lvl(1'b1, 3000);
    endtask : wr

    // Main sequence
    initial begin
        rst_n = 1'b0;
        v = 32'sh0;
        dev_addr = ADDR;
        chop_seen = 1'b0;
        vals[0] = $random(seed) >>> 2;
        repeat (20) @(posedge mclk);
        `CHK({sda_oe_n, sleep_mode, chop_phase, mode_cfg}, 11'h400)
        rst_n <= 1'b1;
        rd(ADDR, 1'b0, 4, 64'h0);
        $display("test busy_refuse done");
        wait_lvl(1'b1, 3000);
        rd(ADDR ^ 7'h01, 1'b0, 4, 64'h0);
        rd(7'h77, 1'b0, 4, 64'h0);
        rd(ADDR, 1'b1, 4, word(32'sh0, 1'b0));
        rd(ADDR, 1'b0, 4, 64'h0);
        $display("test default_read done");
        for (int k = 0; k < 7; k++) begin
            v <= vals[k];
            wait_lvl(1'b1, 3000);
            chop_seen = 1'b0;
            wr(ADDR, cfgs[k], 8);
            dbl = cfgs[k][0] & ~cfgs[k][3];
            `CHK(mode_cfg, {cfgs[k][7:1], dbl})
            `CHK(chop_seen, ~dbl)
            rd(ADDR, 1'b1, 4, word(vals[k], dbl));
        end
        $display("test mode_table done");
        wait_lvl(1'b1, 3000);
        wr(ADDR, 8'hF0, 4);
        `CHK(mode_cfg, 8'h0C)
        wr(7'h77, 8'h00, 8);
        `CHK(mode_cfg, 8'h00)
        $display("test partial_global done");
        rd(ADDR, 1'b1, 1, word(v, 1'b0));
        wait_lvl(1'b0, 300);
        $display("test read_abort done");
        give_verdict();
    end
endmodule : adcx_i2c_conv_tb

// ===== adcx_i2c_master.sv
`timescale 1ns/1ps
module adcx_i2c_master #(
    parameter int H = 52
) (
    // Clock
    input wire logic mclk,
    // Bus pins
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    logic [31:0] got_val;
    event got;

    // Bus idle, both lines released
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
    endtask : hold

    // START, or repeated START from clock low
    task automatic start();
        sda_m <= 1'b1;
        hold(H);
        scl <= 1'b1;
        hold(H);
        sda_m <= 1'b0;
        hold(H);
        scl <= 1'b0;
        hold(8);
    endtask : start

    task automatic stop();
        sda_m <= 1'b0;
        hold(H);
        scl <= 1'b1;
        hold(H);
        sda_m <= 1'b1;
        hold(H);
    endtask : stop

    // One clock; data set while low, sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        hold(H);
        scl <= 1'b1;
        hold(H);
        r = sda;
        scl <= 1'b0;
        hold(8);
    endtask : bit_io

    // Seven address bits, then direction
    task automatic addr(input logic [7:0] a, output logic ack);
        logic r;
        start();
        for (int i = 7; i >= 0; i--) bit_io(a[i], r);
        bit_io(1'b1, r);
        ack = !r;
        got_val = {31'h0, ack};
        ->got;
    endtask : addr

    // Write nb data bits; fewer than 8 ends mid-byte
    task automatic wr(input logic [6:0] a, input logic [7:0] d, input int nb);
        logic ack;
        logic r;
        addr({a, 1'b0}, ack);
        for (int i = 7; ack && i > 7 - nb; i--) bit_io(d[i], r);
        if (ack && nb == 8) bit_io(1'b1, r);
        stop();
    endtask : wr

    // Read nb bytes, NAK the last, then STOP ends the output phase
    task automatic rd(input logic [6:0] a, input int nb);
        logic ack;
        logic r;
        logic [31:0] w;
        addr({a, 1'b1}, ack);
        w = 32'h0;
        for (int i = 0; ack && i < 9 * nb; i++) begin
            bit_io((i % 9 != 8) || (i == 9 * nb - 1), r);
            if (i % 9 != 8) w = {w[30:0], r};
        end
        if (ack) begin
            got_val = w << (8 * (4 - nb));
            ->got;
        end
        stop();
    endtask : rd
endmodule : adcx_i2c_master

// ===== adcx_params.svh
`ifndef ADCX_PARAMS_SVH
`define ADCX_PARAMS_SVH

// Bus addressing
`define ADCX_GLOBAL_ADDR 7'h77
`define ADCX_BYTE_BITS 4'h8
`define ADCX_FIRST_BIT 5'h1F
`define ADCX_LAST_BIT 5'h00

// Configuration reset value: external input, 50/60Hz rejection, 1x speed
`define ADCX_CFG_RESET 8'h00

// Conversion phase length in mclk cycles (default of a top parameter)
`define ADCX_CONV_CYCLES 20000

// Full-scale limits of the raw filter value, in sub-LSB units
`define ADCX_FS_POS 32'sh40000000
`define ADCX_FS_NEG 32'shC0000000

// Fixed output words for out-of-range inputs, and the ones field checked in an underrange word
`define ADCX_OVER_WORD 32'hC0000000
`define ADCX_UNDER_WORD 32'h3FFFFFFF
`define ADCX_UNDER2X_WORD 32'h3FFF0000
`define ADCX_RANGE_LO_ONES 24'hFFFFFF

`endif

// ===== adcx_pkg.sv
package adcx_pkg;

    // Operating mode word, first received bit in the MSB
    typedef struct packed {
        logic [3:0] rsvd;
        logic input_select_temp;
        logic reject_sel_hi;
        logic reject_sel_lo;
        logic double_rate_select;
    } adcx_cfg_t;

    // Link-side transfer states
    typedef enum logic [2:0] {
        LK_IDLE = 3'b000,
        LK_ADDR = 3'b001,
        LK_AACK = 3'b010,
        LK_WDAT = 3'b011,
        LK_WACK = 3'b100,
        LK_RDAT = 3'b101,
        LK_RACK = 3'b110,
        LK_SKIP = 3'b111
    } adcx_link_st_t;

    // Converter sequencing states
    typedef enum logic [1:0] {
        CV_CONV1 = 2'b00,
        CV_CONV2 = 2'b01,
        CV_SLEEP = 2'b10
    } adcx_conv_st_t;

endpackage : adcx_pkg
